// ===== hdl/phy_ctrl_pkg.sv
// constants, carriers and states shared by the link control block
package phy_ctrl_pkg;
  localparam int CLK_MHZ = 100;
  localparam int MAC_FAST_MHZ10 = 250;
  localparam int MAC_SLOW_MHZ10 = 25;
  localparam int MAC_HALF_FAST = (CLK_MHZ * 10) / (2 * MAC_FAST_MHZ10);
  localparam int MAC_HALF_SLOW = (CLK_MHZ * 10) / (2 * MAC_SLOW_MHZ10);
  localparam int SLOW_PHASE_US = 16;
  localparam logic [10:0] SLOW_PHASE_CYCLES = 11'(SLOW_PHASE_US * CLK_MHZ);
  localparam int LINK_WAIT_MS = 330;
  localparam int LINK_WAIT_CYCLES_DEF = LINK_WAIT_MS * CLK_MHZ * 1000;
  localparam logic [4:0] SOFT_RST_CYCLES = 5'h10;
  localparam int COL_TEST_ASSERT_BT = 512;
  localparam int COL_TEST_RELEASE_BT = 4;

  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;

  localparam int CTRL_SOFT_RESET_BIT = 15;
  localparam int CTRL_LOOPBACK_BIT = 14;
  localparam int CTRL_AUTONEG_BIT = 12;
  localparam int CTRL_POWER_DOWN_BIT = 11;
  localparam int CTRL_ISOLATE_BIT = 10;
  localparam int CTRL_FULL_DUPLEX_BIT = 8;
  localparam int CTRL_COLL_TEST_BIT = 7;
  localparam int CTRL_REPEATER_BIT = 4;
  localparam int CTRL_TEN_MODE_BIT = 3;
  localparam int CTRL_RMII_BIT = 2;
  localparam int CTRL_FAR_ECHO_BIT = 1;
  localparam logic [15:0] CTRL_RESET = 16'h1000;
  localparam logic [15:0] CTRL_WRITABLE = 16'hDD9E;
  localparam logic [15:0] CTRL_PERSIST_MASK = 16'h0014;

  localparam int STS_CARRIER_BIT = 0;
  localparam int STS_COL_BIT = 1;
  localparam int STS_LINK_BIT = 2;
  localparam int STS_MAC_FAST_BIT = 3;
  localparam int STS_STATE_LSB = 8;

  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0D;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [4:0] SYM_IDLE = 5'h1F;
  localparam logic [9:0] CS_WIN_IDLE = 10'h3FF;

  typedef enum logic [1:0] {link_down, link_wait, link_ready, link_up} link_state_type;
  typedef enum logic [1:0] {cs_idle, cs_pre, cs_frame} cs_state_type;

  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] d;
  } mac_tx_type;

  typedef struct packed {
    logic crs;
    logic crs_dv;
    logic col;
    logic dv;
    logic [3:0] d;
  } mac_rx_type;
endpackage

// ===== hdl/carrier_detect.sv
// carrier detection on the encoded, unscrambled receive bit stream
`timescale 1ns/100ps
module carrier_detect
  import phy_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic bit_strobe,
  input wire logic bit_in,
  output logic carrier
);
  typedef struct packed {
    cs_state_type st;
    logic [9:0] win;
    logic [2:0] cnt;
    logic pend;
    logic pend_idle;
    logic carrier;
  } cs_type;

  cs_type s;
  cs_type next_s;
  logic [9:0] w;

  function automatic logic two_zeros(input logic [9:0] v);
    logic found;
    found = 1'b0;
    for (int i = 0; i < 10; i++) begin
      for (int j = i + 2; j < 10; j++) begin
        if (!v[i] && !v[j]) begin
          found = 1'b1;
        end
      end
    end
    return found;
  endfunction

  assign w = {s.win[8:0], bit_in};
  assign carrier = s.carrier;

  always_comb begin
    next_s = s;
    if (bit_strobe) begin
      next_s.win = w;
      case (s.st)
        cs_idle: begin
          if (two_zeros(w)) begin
            next_s.carrier = 1'b1;
            next_s.st = cs_pre;
          end
        end
        cs_pre: begin
          if (w == CS_WIN_IDLE) begin
            next_s.carrier = 1'b0;
            next_s.st = cs_idle;
          end else if (w == {SYM_J, SYM_K}) begin
            next_s.st = cs_frame;
            next_s.cnt = 3'h0;
            next_s.pend = 1'b0;
          end
        end
        cs_frame: begin
          next_s.cnt = (s.cnt == 3'h4) ? 3'h0 : s.cnt + 3'h1;
          if (s.cnt == 3'h4) begin
            if (s.pend) begin
              if ((!s.pend_idle && w[4:0] == SYM_R) || (s.pend_idle && w[4:0] == SYM_IDLE)) begin
                next_s.st = cs_idle;
                // stream end leaves no stale zeros
                next_s.win = CS_WIN_IDLE;
              end else begin
                next_s.carrier = 1'b1;
                next_s.pend = 1'b0;
              end
            end else if (w[4:0] == SYM_T || w[4:0] == SYM_IDLE) begin
              next_s.carrier = 1'b0;
              next_s.pend = 1'b1;
              next_s.pend_idle = (w[4:0] == SYM_IDLE);
            end
          end
        end
        default: begin
          next_s.st = cs_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.win <= CS_WIN_IDLE;
    end else begin
      s <= next_s;
    end
  end
endmodule // carrier_detect

// ===== hdl/phy_link_ctrl.sv
// isolate, reset, carrier, collision, link monitor and loopback control
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
module phy_link_ctrl
  import phy_ctrl_pkg::*;
#(
  parameter int unsigned LINK_WAIT_CYCLES = LINK_WAIT_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack,
  input wire phy_ctrl_pkg::mac_tx_type mac_tx,
  output phy_ctrl_pkg::mac_rx_type mac_rx,
  output logic mac_clk,
  input wire logic line_valid,
  input wire logic autoneg_grant,
  input wire logic link10_status,
  input wire logic rx_code_bit,
  input wire logic rx_code_clk,
  input wire logic [3:0] line_rxd,
  input wire logic line_rx_dv,
  output logic line_tx_en,
  output logic [3:0] line_txd,
  output logic line_echo,
  output logic mac_isolated,
  output logic link_indicator_output
);
  import phy_ctrl_pkg::*;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [4:0] srst_cnt;
    logic ack;
    logic [31:0] dat;
    mac_tx_type tx1;
    mac_tx_type tx2;
    logic lv1;
    logic lv2;
    logic an1;
    logic an2;
    logic l10_1;
    logic l10_2;
    logic rb1;
    logic rb2;
    logic rc1;
    logic rc2;
    logic rc3;
    logic [3:0] lrxd;
    logic lrx_dv;
    link_state_type link;
    logic [25:0] wait_cnt;
    logic [10:0] slow_cnt;
    logic [4:0] div_cnt;
    logic mac_clk;
    mac_rx_type rx;
    logic tx_en;
    logic [3:0] txd;
    logic echo;
    logic isolated;
    logic led;
    logic col;
    logic carrier;
  } state_type;

  state_type s;
  state_type next_s;

  logic carrier;
  logic lb;
  logic pd;
  logic fd_or_rep;
  logic far;
  logic iso;
  logic up;
  logic tx_act;
  logic rx_act;
  logic crs;
  logic col;
  logic link_ok;
  logic mac_fast;
  logic take;
  logic wr;
  logic [15:0] wr_word;
  logic [4:0] half;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
    logic [15:0] m;
    m = old;
    if (sel[0]) begin
      m[7:0] = d[7:0];
    end
    if (sel[1]) begin
      m[15:8] = d[15:8];
    end
    return m;
  endfunction

  carrier_detect u_carrier (
    .clk(clk),
    .rst(rst),
    .bit_strobe(s.rc2 & ~s.rc3),
    .bit_in(s.rb2),
    .carrier(carrier)
  );

  assign lb = s.ctrl[CTRL_LOOPBACK_BIT];
  assign pd = s.ctrl[CTRL_POWER_DOWN_BIT];
  assign fd_or_rep = s.ctrl[CTRL_FULL_DUPLEX_BIT] | s.ctrl[CTRL_REPEATER_BIT];
  assign far = s.ctrl[CTRL_FAR_ECHO_BIT] & s.ctrl[CTRL_RMII_BIT];
  assign iso = s.ctrl[CTRL_ISOLATE_BIT] | far;
  assign up = (s.link == link_up);
  assign tx_act = s.tx2.en & ~iso;
  assign rx_act = lb ? tx_act : (carrier & ~pd);
  assign crs = fd_or_rep ? rx_act : (rx_act | tx_act);
  assign col = s.ctrl[CTRL_COLL_TEST_BIT] ? tx_act
             : (tx_act & rx_act & ~s.ctrl[CTRL_FULL_DUPLEX_BIT] & ~lb);
  assign link_ok = s.ctrl[CTRL_TEN_MODE_BIT] ? s.l10_2 : up;
  assign mac_fast = (s.slow_cnt == 11'h000) & s.ctrl[CTRL_AUTONEG_BIT];
  assign half = mac_fast ? 5'(MAC_HALF_FAST) : 5'(MAC_HALF_SLOW);
  assign take = wb_cyc & wb_stb & ~s.ack;
  assign wr = s.ack & wb_cyc & wb_stb & wb_we & (wb_adr == CTRL_ADDR) & (s.srst_cnt == 5'h00);
  assign wr_word = merge(s.ctrl, wb_dat_i, wb_sel) & CTRL_WRITABLE;

  always_comb begin
    next_s = s;
    next_s.tx1 = mac_tx;
    next_s.tx2 = s.tx1;
    next_s.lv1 = line_valid;
    next_s.lv2 = s.lv1;
    next_s.an1 = autoneg_grant;
    next_s.an2 = s.an1;
    next_s.l10_1 = link10_status;
    next_s.l10_2 = s.l10_1;
    next_s.rb1 = rx_code_bit;
    next_s.rb2 = s.rb1;
    next_s.rc1 = rx_code_clk;
    next_s.rc2 = s.rc1;
    next_s.rc3 = s.rc2;
    next_s.lrxd = line_rxd;
    next_s.lrx_dv = line_rx_dv;
    next_s.carrier = carrier;
    next_s.col = col;

    next_s.ack = take;
    if (take && !wb_we) begin
      case (wb_adr)
        CTRL_ADDR: begin
          next_s.dat = {16'h0000, s.ctrl};
        end
        STATUS_ADDR: begin
          next_s.dat = '0;
          next_s.dat[STS_CARRIER_BIT] = s.carrier;
          next_s.dat[STS_COL_BIT] = s.col;
          next_s.dat[STS_LINK_BIT] = s.led;
          next_s.dat[STS_MAC_FAST_BIT] = mac_fast;
          next_s.dat[STS_STATE_LSB +: 2] = s.link;
        end
        default: begin
          next_s.dat = '0;
        end
      endcase
    end

    if (wr) begin
      if (wr_word[CTRL_SOFT_RESET_BIT]) begin
        next_s.ctrl = (CTRL_RESET & ~CTRL_PERSIST_MASK) | (s.ctrl & CTRL_PERSIST_MASK);
        next_s.ctrl[CTRL_SOFT_RESET_BIT] = 1'b1;
        next_s.srst_cnt = SOFT_RST_CYCLES;
        next_s.slow_cnt = SLOW_PHASE_CYCLES;
        next_s.link = link_down;
        next_s.wait_cnt = '0;
      end else begin
        next_s.ctrl = wr_word;
      end
    end

    if (s.srst_cnt != 5'h00) begin
      next_s.srst_cnt = s.srst_cnt - 5'h01;
      next_s.slow_cnt = SLOW_PHASE_CYCLES;
      if (s.srst_cnt == 5'h01) begin
        next_s.ctrl[CTRL_SOFT_RESET_BIT] = 1'b0;
      end
    end else if (s.slow_cnt != 11'h000) begin
      next_s.slow_cnt = s.slow_cnt - 11'h001;
    end

    if (s.div_cnt >= half - 5'h01) begin
      next_s.div_cnt = 5'h00;
      next_s.mac_clk = ~s.mac_clk;
    end else begin
      next_s.div_cnt = s.div_cnt + 5'h01;
    end

    if (!s.lv2 || s.srst_cnt != 5'h00) begin
      next_s.link = link_down;
      next_s.wait_cnt = '0;
    end else begin
      case (s.link)
        link_down: begin
          next_s.link = s.ctrl[CTRL_AUTONEG_BIT] ? link_wait : link_up;
          next_s.wait_cnt = '0;
        end
        link_wait: begin
          if (s.wait_cnt >= 26'(LINK_WAIT_CYCLES - 1)) begin
            next_s.link = link_ready;
          end else begin
            next_s.wait_cnt = s.wait_cnt + 26'h0000001;
          end
        end
        link_ready: begin
          if (s.an2) begin
            next_s.link = link_up;
          end
        end
        link_up: begin
          next_s.link = link_up;
        end
        default: begin
          next_s.link = link_down;
        end
      endcase
    end

    next_s.led = link_ok;

    next_s.rx = '0;
    if (!iso) begin
      next_s.rx.crs = crs & ~s.ctrl[CTRL_RMII_BIT];
      next_s.rx.crs_dv = crs & s.ctrl[CTRL_RMII_BIT];
      // overlap collision, none in full duplex or loopback; collision test forces col on transmit
      next_s.rx.col = col;
      next_s.rx.dv = lb ? tx_act : (s.lrx_dv & up);
      next_s.rx.d = lb ? s.tx2.d : s.lrxd;
    end
    next_s.isolated = iso;

    next_s.echo = far;
    if (far) begin
      next_s.tx_en = s.lrx_dv & ~pd;
      next_s.txd = s.lrxd;
    end else begin
      next_s.tx_en = tx_act & up & ~lb & ~pd;
      next_s.txd = (tx_act & up & ~lb & ~pd) ? s.tx2.d : 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.slow_cnt <= SLOW_PHASE_CYCLES;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack = s.ack;
  assign wb_dat_o = s.dat;
  assign mac_rx = s.rx;
  assign mac_clk = s.mac_clk;
  assign line_tx_en = s.tx_en;
  assign line_txd = s.txd;
  assign line_echo = s.echo;
  assign mac_isolated = s.isolated;
  assign link_indicator_output = s.led;
endmodule // phy_link_ctrl

// ===== dv/phy_link_ctrl_assertions.sv
// port checks for the link control block
`timescale 1ns/100ps
module phy_link_ctrl_assertions
  import phy_ctrl_pkg::*;
#(
  parameter int unsigned LINK_WAIT_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack,
  input wire phy_ctrl_pkg::mac_tx_type mac_tx,
  input wire phy_ctrl_pkg::mac_rx_type mac_rx,
  input wire logic mac_clk,
  input wire logic line_valid,
  input wire logic line_echo,
  input wire logic mac_isolated,
  input wire logic link_indicator_output
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [10:0] since_rst;
  always_ff @(posedge clk) begin
    if (rst) begin
      since_rst <= 11'h000;
    end else if (since_rst != 11'h7FF) begin
      since_rst <= since_rst + 11'h001;
    end
  end
  sequence s_take;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  sequence s_read_other;
    s_take ##0 (!wb_we && wb_adr != CTRL_ADDR && wb_adr != STATUS_ADDR);
  endsequence
  property p_ack_next;
    s_take |=> wb_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered");
  property p_ack_pulse;
    wb_ack |=> !wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_unmapped_zero;
    s_read_other |=> wb_dat_o == 32'h00000000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_iso_quiet;
    mac_isolated && $past(mac_isolated) |-> mac_rx == '0;
  endproperty
  a_iso_quiet: assert property (p_iso_quiet) else $error("mac outputs active while isolated");
  property p_echo_iso;
    line_echo && $past(line_echo) |-> mac_isolated;
  endproperty
  a_echo_iso: assert property (p_echo_iso) else $error("far echo without isolation");
  property p_one_carrier;
    !(mac_rx.crs && mac_rx.crs_dv);
  endproperty
  a_one_carrier: assert property (p_one_carrier) else $error("carrier on both pins");
  property p_link_drop;
    $fell(line_valid) |-> ##[1:5] !link_indicator_output;
  endproperty
  a_link_drop: assert property (p_link_drop) else $error("link kept after signal loss");
  property p_slow_clk;
    $changed(mac_clk) && since_rst > 11'h002 && since_rst < 11'h5DC |=> $stable(mac_clk) [*8];
  endproperty
  a_slow_clk: assert property (p_slow_clk) else $error("mac clock fast in slow phase");
  property p_col_release;
    $fell(mac_tx.en) |-> ##[1:4] !mac_rx.col;
  endproperty
  a_col_release: assert property (p_col_release) else $error("collision kept after transmit end");
endmodule // phy_link_ctrl_assertions

// ===== dv/mac_line_model.sv
// peer model: mac transmit side and encoded line bit source
`timescale 1ns/100ps
module mac_line_model (
  input wire logic clk,
  output phy_ctrl_pkg::mac_tx_type mac_tx,
  output logic code_bit,
  output logic code_clk
);
  import phy_ctrl_pkg::*;
  initial begin
    mac_tx = '0;
    code_bit = 1'b0;
    code_clk = 1'b0;
  end
  task automatic drive_tx(input logic en, input logic [3:0] d);
    @(posedge clk);
    mac_tx <= '{en, 1'b0, d};
  endtask
  // bit clock runs only while send_code shifts out a code word, msb first
  task automatic send_code(input logic [19:0] v, input int n);
    @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      code_bit <= v[i];
      repeat (4) @(posedge clk);
      code_clk <= 1'b1;
      repeat (4) @(posedge clk);
      code_clk <= 1'b0;
    end
    code_bit <= ~code_bit;
  endtask
endmodule // mac_line_model

// ===== dv/tb.sv
// top bench for the link control block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import phy_ctrl_pkg::*;
  logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, mac_clk, line_valid, grant, link10;
  logic code_bit, code_clk, line_rx_dv, line_tx_en, line_echo, mac_isolated, led;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel, line_rxd, line_txd;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  mac_tx_type mac_tx;
  mac_rx_type mac_rx;
  int errors = 0;
  int samples_checked = 0;
  logic [19:0] modes [10] = '{20'h0000A, 20'h01002, 20'h00102, 20'h0004A, 20'h0080E,
    20'h40008, 20'h4080C, 20'h04001, 20'h0002A, 20'h00061};
  phy_link_ctrl #(.LINK_WAIT_CYCLES(50)) u_dut (.clk(clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack(wb_ack), .mac_tx(mac_tx), .mac_rx(mac_rx), .mac_clk(mac_clk), .line_valid(line_valid),
    .autoneg_grant(grant), .link10_status(link10), .rx_code_bit(code_bit), .rx_code_clk(code_clk),
    .line_rxd(line_rxd), .line_rx_dv(line_rx_dv), .line_tx_en(line_tx_en), .line_txd(line_txd),
    .line_echo(line_echo), .mac_isolated(mac_isolated), .link_indicator_output(led));
  mac_line_model u_peer (.clk(clk), .mac_tx(mac_tx), .code_bit(code_bit), .code_clk(code_clk));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic we, input logic [7:0] adr, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'hF;
    wb_adr <= adr;
    wb_dat_i <= {16'h0000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    r = wb_dat_o;
    if (n >= 50) begin
      errors++;
      end_of_test();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic chk_crs(input logic [19:0] v, input int n, input logic e);
    u_peer.send_code(v, n);
    idle(6);
    `CHK("crs", e, mac_rx.crs)
  endtask
  initial begin
    {rst, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_i} = {1'b1, 47'h0};
    {line_valid, grant, link10, line_rxd, line_rx_dv} = 8'h00;
    idle(6);
    rst <= 1'b0;
    bus(1'b0, CTRL_ADDR, 16'h0000);
    `CHK("ctrl reset", 32'h00001000, r)
    bus(1'b0, 8'h08, 16'h0000);
    `CHK("unmapped", 32'h00000000, r)
    bus(1'b0, STATUS_ADDR, 16'h0000);
    `CHK("mac fast early", 1'b0, r[STS_MAC_FAST_BIT])
    idle(1650);
    bus(1'b0, STATUS_ADDR, 16'h0000);
    `CHK("mac fast late", 1'b1, r[STS_MAC_FAST_BIT])
    line_valid <= 1'b1;
    idle(30);
    `CHK("led wait", 1'b0, led)
    idle(40);
    bus(1'b0, STATUS_ADDR, 16'h0000);
    `CHK("link ready", 2'h2, r[STS_STATE_LSB +: 2])
    grant <= 1'b1;
    idle(8);
    `CHK("led up", 1'b1, led)
    line_valid <= 1'b0;
    idle(8);
    `CHK("led lost", 1'b0, led)
    bus(1'b1, CTRL_ADDR, 16'h0008);
    link10 <= 1'b1;
    idle(8);
    `CHK("led ten", 1'b1, led)
    bus(1'b1, CTRL_ADDR, 16'h0814);
    bus(1'b0, CTRL_ADDR, 16'h0000);
    `CHK("power-down keeps", 32'h00000814, r)
    bus(1'b1, CTRL_ADDR, 16'h8814);
    bus(1'b0, CTRL_ADDR, 16'h0000);
    `CHK("soft busy", 1'b1, r[CTRL_SOFT_RESET_BIT])
    idle(20);
    bus(1'b0, CTRL_ADDR, 16'h0000);
    `CHK("soft done", 32'h00001014, r)
    bus(1'b1, CTRL_ADDR, 16'h0000);
    line_valid <= 1'b1;
    idle(6);
    `CHK("led no autoneg", 1'b1, led)
    chk_crs(20'hFFFFF, 20, 1'b0);
    chk_crs(20'h003BB, 10, 1'b1);
    chk_crs(20'h003FF, 10, 1'b0);
    chk_crs({SYM_J, SYM_K, 5'h0A, 5'h0E}, 20, 1'b1);
    chk_crs({10'h000, SYM_T, 5'h0A}, 10, 1'b1);
    chk_crs({10'h000, SYM_IDLE, 5'h0A}, 10, 1'b1);
    chk_crs({10'h000, SYM_T, SYM_R}, 10, 1'b0);
    foreach (modes[i]) begin
      bus(1'b1, CTRL_ADDR, modes[i][19:4]);
      u_peer.drive_tx(1'b1, 4'hA);
      idle(8);
      `CHK("carrier", modes[i][3], modes[i][6] ? mac_rx.crs_dv : mac_rx.crs)
      `CHK("col", modes[i][2], mac_rx.col)
      `CHK("line tx", modes[i][1], line_tx_en)
      `CHK("isolated", modes[i][0], mac_isolated)
      if (modes[i][18]) `CHK("loop data", 4'hA, mac_rx.d)
      if (modes[i][18]) `CHK("loop dv", 1'b1, mac_rx.dv)
      `CHK("line txd", modes[i][1] ? 4'hA : 4'h0, line_txd)
      `CHK("echo", modes[i][5] & modes[i][6], line_echo)
      u_peer.drive_tx(1'b0, 4'h0);
      idle(8);
      `CHK("col release", 1'b0, mac_rx.col)
    end
    line_rxd <= 4'h5;
    line_rx_dv <= 1'b1;
    idle(4);
    `CHK("echo en", 1'b1, line_tx_en)
    `CHK("echo data", 4'h5, line_txd)
    `CHK("echo mac dv", 1'b0, mac_rx.dv)
    line_rx_dv <= 1'b0;
    bus(1'b1, CTRL_ADDR, 16'h0000);
    u_peer.send_code(20'h003BB, 10);
    u_peer.drive_tx(1'b1, 4'h3);
    idle(8);
    `CHK("col overlap", 1'b1, mac_rx.col)
    bus(1'b0, STATUS_ADDR, 16'h0000);
    `CHK("status col", 1'b1, r[STS_COL_BIT])
    `CHK("status carrier", 1'b1, r[STS_CARRIER_BIT])
    bus(1'b1, CTRL_ADDR, 16'h0100);
    idle(4);
    `CHK("col full duplex", 1'b0, mac_rx.col)
    `CHK("crs receive only", 1'b1, mac_rx.crs)
    u_peer.drive_tx(1'b0, 4'h0);
    idle(8);
    end_of_test();
  end
  initial begin
    idle(100000);
    errors++;
    end_of_test();
  end
endmodule // tb
bind phy_link_ctrl phy_link_ctrl_assertions #(.LINK_WAIT_CYCLES(LINK_WAIT_CYCLES)) u_chk (.clk(clk), .rst(rst),
  .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack),
  .mac_tx(mac_tx), .mac_rx(mac_rx), .mac_clk(mac_clk), .line_valid(line_valid), .line_echo(line_echo),
  .mac_isolated(mac_isolated), .link_indicator_output(link_indicator_output));
